// File: hdl/dbu_defines.vh
// constants for the debug breakpoint unit: register numbers, field layouts,
// cause codes, writable masks and reset values.
// assumes inclusion by bare name from the unit's design files.
`ifndef DBU_DEFINES_VH
`define DBU_DEFINES_VH

// register numbers on the processor status port
`define DBU_OFF_SAVED_STATUS 8'h10
`define DBU_OFF_SAVED_PC 8'h11
`define DBU_OFF_SAVED_SP 8'h12
`define DBU_OFF_FETCH_THREAD 8'h13
`define DBU_OFF_FETCH_REGNUM 8'h14
`define DBU_OFF_CAUSE_INFO 8'h15
`define DBU_OFF_CAUSE_DATA 8'h16
`define DBU_OFF_HALT_MASK 8'h18
`define DBU_OFF_SCRATCH 8'h20
`define DBU_OFF_IB_ADDR 8'h30
`define DBU_OFF_IB_CTRL 8'h40
// masks that group the banked registers
`define DBU_SCRATCH_MASK 8'hf8
`define DBU_BANK4_MASK 8'hfc

// saved status word fields
`define DBU_SSW_WIDTH 11
`define DBU_SSW_EVENTS_EN 0
`define DBU_SSW_INTS_EN 1
`define DBU_SSW_IN_EE_SEQ 2
`define DBU_SSW_IN_HANDLER 3
`define DBU_SSW_KERNEL 4
`define DBU_SSW_PAUSED 6
`define DBU_SSW_FAST 7
`define DBU_SSW_ISSUE_MODE 8
`define DBU_SSW_ISSUE_KENTRY 9
`define DBU_SSW_ASID 10
// bits 5 and 8 are not writable by software
`define DBU_SSW_WR_MASK 11'h6df

// cause information fields
`define DBU_CI_CAUSE_LSB 0
`define DBU_CI_CAUSE_MSB 2
`define DBU_CI_THREAD_LSB 8
`define DBU_CI_THREAD_MSB 15
`define DBU_CI_INDEX_LSB 16
`define DBU_CI_INDEX_MSB 17
`define DBU_CI_WR_MASK 32'h0003ff07

// cause codes
`define DBU_CAUSE_NONE 3'h0
`define DBU_CAUSE_HOST 3'h1
`define DBU_CAUSE_DEBUG_CALL_INSTR 3'h2
`define DBU_CAUSE_IBREAK 3'h3
`define DBU_CAUSE_DWATCH 3'h4
`define DBU_CAUSE_RWATCH 3'h5

// instruction breakpoint control fields
`define DBU_IBC_ENABLE 0
`define DBU_IBC_NOT_EQUAL 1
`define DBU_IBC_THREADS_LSB 16
`define DBU_IBC_THREADS_MSB 23
`define DBU_IBC_WR_MASK 32'h00ff0003

// operand field masks
`define DBU_FETCH_THREAD_MASK 32'h000000ff
`define DBU_FETCH_REGNUM_MASK 32'h0000001f
`define DBU_HALT_MASK_BITS 32'h000000ff

// reset values
`define DBU_RST_WORD 32'h00000000
`define DBU_RST_IB_CTRL 32'h00000000

`endif

// File: hdl/dbu_ibreak_match.v
// one instruction breakpoint comparator.
// assumes the pc and thread inputs are registered on the core clock.
`timescale 1ns/1ns
`include "dbu_defines.vh"
module dbu_ibreak_match #(
    parameter NUM_THREADS = 8
) (
    input wire [31:0] break_addr_in,
    input wire [31:0] break_ctrl_in,
    input wire pc_valid_in,
    input wire [31:0] pc_in,
    input wire [2:0] pc_thread_in,
    output wire hit_out
);
    wire enabled; // breakpoint armed
    wire addr_equal; // pc equals stored address
    wire cond_met; // equal or not-equal condition
    wire [NUM_THREADS-1:0] thread_en; // per-thread enables
    wire thread_ok; // current thread allowed

    assign addr_equal = (pc_in == break_addr_in);
    assign cond_met = break_ctrl_in[`DBU_IBC_NOT_EQUAL] ? ~addr_equal : addr_equal;
    assign thread_en = break_ctrl_in[`DBU_IBC_THREADS_MSB:`DBU_IBC_THREADS_LSB];
    assign thread_ok = thread_en[pc_thread_in];
    assign enabled = break_ctrl_in[`DBU_IBC_ENABLE];
    assign hit_out = enabled & cond_met & thread_ok & pc_valid_in;
endmodule // dbu_ibreak_match

// File: hdl/dbu_breakpoint_unit.v
// debug breakpoint unit: debug entry capture, cause recording, instruction
// breakpoints, halt mask, register-fetch operands and shared scratch words.
// assumes all inputs come from logic on mclk_in, host requests included.
`timescale 1ns/1ns
`include "dbu_defines.vh"
// Behaviour
// - copy interrupted status word on entry
// - status bits zero to four layout
// - status bits six to ten layout
// - store full interrupted pc on entry
// - store interrupted stack pointer, software writable
// - fetch operands: thread and register number
// - three-bit cause code, resets zero
// - lowest triggering index, zero otherwise
// - causing thread number, zero for host
// - address or resource id in data
// - halt mask stops threads outside debug
// - eight scratch words, two access paths
// - four instruction breakpoints raise entry
// - breakpoint fires only when enabled
// - condition bit: equal or differs
// - per-thread breakpoint enables, reset zero
module dbu_breakpoint_unit #(
    parameter NUM_BREAKS = 4,
    parameter NUM_SCRATCH = 8
) (
    input wire mclk_in,
    input wire rst_in,
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_wdata_in,
    output reg [31:0] reg_rdata_out,
    input wire [7:0] cfg_addr_in,
    input wire cfg_wr_in,
    input wire cfg_rd_in,
    input wire [31:0] cfg_wdata_in,
    output reg [31:0] cfg_rdata_out,
    input wire host_req_in,
    input wire debug_call_instr_in,
    input wire [2:0] debug_call_instr_thread_in,
    input wire pc_valid_in,
    input wire [31:0] pc_in,
    input wire [2:0] pc_thread_in,
    input wire [3:0] dwatch_hit_in,
    input wire [2:0] dwatch_thread_in,
    input wire [31:0] dwatch_addr_in,
    input wire [3:0] rwatch_hit_in,
    input wire [2:0] rwatch_thread_in,
    input wire [31:0] rwatch_resid_in,
    input wire [10:0] ctx_ssr_in,
    input wire [31:0] ctx_pc_in,
    input wire [31:0] ctx_sp_in,
    input wire debug_return_in,
    output reg [2:0] ctx_thread_out,
    output wire ctx_capture_out,
    output wire debug_enter_out,
    output wire debug_mode_out,
    output wire [7:0] thread_halt_out,
    output wire [7:0] fetch_thread_out,
    output wire [4:0] fetch_regnum_out,
    output wire [10:0] saved_status_word_out,
    output wire [31:0] saved_program_counter_out,
    output wire [31:0] saved_stack_pointer_out
);
    // one-hot states of the entry sequence
    localparam ST_IDLE = 4'b0001; // threads running
    localparam ST_CAPTURE = 4'b0010; // context of chosen thread sampled
    localparam ST_ENTER = 4'b0100; // handler may start
    localparam ST_DEBUG = 4'b1000; // handler running

    // lowest set index of a four-bit hit vector
    function [1:0] dbu_lowest;
        input [3:0] hits;
        begin
            if (hits[0]) begin
                dbu_lowest = 2'h0;
            end else if (hits[1]) begin
                dbu_lowest = 2'h1;
            end else if (hits[2]) begin
                dbu_lowest = 2'h2;
            end else begin
                dbu_lowest = 2'h3;
            end
        end
    endfunction

    // true when an address falls in a banked group
    function dbu_in_bank;
        input [7:0] addr;
        input [7:0] mask;
        input [7:0] base;
        begin
            dbu_in_bank = ((addr & mask) == base);
        end
    endfunction

    reg [3:0] state; // sequence state
    reg [3:0] next_state; // next sequence state
    reg [10:0] saved_status; // saved status word copy
    reg [31:0] saved_pc; // saved program counter
    reg [31:0] saved_sp; // saved stack pointer
    reg [7:0] fetch_thread; // fetch thread operand
    reg [4:0] fetch_regnum; // fetch register operand
    reg [2:0] cause; // cause code
    reg [7:0] cause_thread; // causing thread
    reg [1:0] cause_index; // triggering index
    reg [31:0] cause_data; // address or resource id
    reg [7:0] halt_mask; // thread halt mask
    reg [31:0] scratch [0:NUM_SCRATCH-1]; // shared scratch words
    reg [31:0] ib_addr [0:NUM_BREAKS-1]; // breakpoint addresses
    reg [31:0] ib_ctrl [0:NUM_BREAKS-1]; // breakpoint controls
    wire [NUM_BREAKS-1:0] ib_hit; // breakpoint hits this cycle
    wire [3:0] ib_hit4; // hits widened to four
    reg trig; // some source triggers
    reg [2:0] next_cause; // cause of this trigger
    reg [2:0] next_thread; // thread of this trigger
    reg [1:0] next_index; // index of this trigger
    reg [31:0] next_data; // data of this trigger
    reg next_data_load; // data register is loaded
    reg [31:0] rd_word; // status port read mux
    reg [31:0] cfg_word; // config port read mux
    wire idle; // in idle state
    wire wr_ok; // status port write allowed
    wire [1:0] reg_bank; // low bits of banked address
    wire [2:0] reg_scr; // status port scratch index
    wire [2:0] cfg_scr; // config port scratch index
    integer i; // reset loop index
    integer j; // scratch reset loop index

    assign idle = (state == ST_IDLE);
    assign ctx_capture_out = (state == ST_CAPTURE);
    assign debug_enter_out = (state == ST_ENTER);
    assign debug_mode_out = (state == ST_DEBUG) | (state == ST_ENTER);
    // status port writes take effect only in the debug state, not the enter cycle
    assign wr_ok = reg_wr_in & (state == ST_DEBUG);
    assign reg_bank = reg_addr_in[1:0];
    assign reg_scr = reg_addr_in[2:0];
    assign cfg_scr = cfg_addr_in[2:0];
    assign thread_halt_out = debug_mode_out ? 8'h00 : halt_mask;
    assign fetch_thread_out = fetch_thread;
    assign fetch_regnum_out = fetch_regnum;
    assign saved_status_word_out = saved_status;
    assign saved_program_counter_out = saved_pc;
    assign saved_stack_pointer_out = saved_sp;

    // one comparator per instruction breakpoint
    genvar g;
    generate
        for (g = 0; g < NUM_BREAKS; g = g + 1) begin : gen_ib
            dbu_ibreak_match #(
                .NUM_THREADS(8)
            ) u_match (
                .break_addr_in(ib_addr[g]),
                .break_ctrl_in(ib_ctrl[g]),
                .pc_valid_in(pc_valid_in),
                .pc_in(pc_in),
                .pc_thread_in(pc_thread_in),
                .hit_out(ib_hit[g])
            );
        end
    endgenerate
    assign ib_hit4 = ib_hit[3:0];

    // trigger selection, host first, then call, break, data, resource
    always @* begin
        trig = 1'b0;
        next_cause = `DBU_CAUSE_NONE;
        next_thread = 3'h0;
        next_index = 2'h0;
        next_data = 32'h00000000;
        next_data_load = 1'b0;
        if (host_req_in) begin
            trig = 1'b1;
            next_cause = `DBU_CAUSE_HOST;
        end else if (debug_call_instr_in) begin
            trig = 1'b1;
            next_cause = `DBU_CAUSE_DEBUG_CALL_INSTR;
            next_thread = debug_call_instr_thread_in;
        end else if (|ib_hit4) begin
            trig = 1'b1;
            next_cause = `DBU_CAUSE_IBREAK;
            next_thread = pc_thread_in;
            next_index = dbu_lowest(ib_hit4);
        end else if (|dwatch_hit_in) begin
            trig = 1'b1;
            next_cause = `DBU_CAUSE_DWATCH;
            next_thread = dwatch_thread_in;
            next_index = dbu_lowest(dwatch_hit_in);
            next_data = dwatch_addr_in;
            next_data_load = 1'b1;
        end else if (|rwatch_hit_in) begin
            trig = 1'b1;
            next_cause = `DBU_CAUSE_RWATCH;
            next_thread = rwatch_thread_in;
            next_index = dbu_lowest(rwatch_hit_in);
            next_data = rwatch_resid_in;
            next_data_load = 1'b1;
        end else begin
            trig = 1'b0;
        end
    end

    // entry sequence next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // triggers only count while threads run
                if (trig) begin
                    next_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                next_state = ST_ENTER;
            end
            ST_ENTER: begin
                next_state = ST_DEBUG;
            end
            ST_DEBUG: begin
                // leave on return from the handler
                if (debug_return_in) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // cause recording and context capture
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cause <= `DBU_CAUSE_NONE;
            cause_thread <= 8'h00;
            cause_index <= 2'h0;
            cause_data <= `DBU_RST_WORD;
            ctx_thread_out <= 3'h0;
            saved_status <= 11'h000;
            saved_pc <= `DBU_RST_WORD;
            saved_sp <= `DBU_RST_WORD;
        end else if (idle & trig) begin
            cause <= next_cause;
            cause_thread <= {5'h00, next_thread};
            cause_index <= next_index;
            if (next_data_load) begin
                cause_data <= next_data;
            end
            ctx_thread_out <= next_thread;
        end else if (state == ST_CAPTURE) begin
            saved_status <= ctx_ssr_in & 11'h7df;
            saved_pc <= ctx_pc_in;
            saved_sp <= ctx_sp_in;
        end else if (wr_ok) begin
            case (reg_addr_in)
                `DBU_OFF_SAVED_STATUS: begin
                    saved_status <= (saved_status & ~`DBU_SSW_WR_MASK)
                        | (reg_wdata_in[10:0] & `DBU_SSW_WR_MASK);
                end
                `DBU_OFF_SAVED_PC: begin
                    saved_pc <= reg_wdata_in;
                end
                `DBU_OFF_SAVED_SP: begin
                    saved_sp <= reg_wdata_in;
                end
                `DBU_OFF_CAUSE_INFO: begin
                    cause <= reg_wdata_in[`DBU_CI_CAUSE_MSB:`DBU_CI_CAUSE_LSB];
                    cause_thread <= reg_wdata_in[`DBU_CI_THREAD_MSB:`DBU_CI_THREAD_LSB];
                    cause_index <= reg_wdata_in[`DBU_CI_INDEX_MSB:`DBU_CI_INDEX_LSB];
                end
                `DBU_OFF_CAUSE_DATA: begin
                    cause_data <= reg_wdata_in;
                end
                default: begin
                    cause <= cause;
                end
            endcase
        end
    end

    // operands, halt mask and breakpoint registers
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            fetch_thread <= 8'h00;
            fetch_regnum <= 5'h00;
            halt_mask <= 8'h00;
            for (i = 0; i < NUM_BREAKS; i = i + 1) begin
                ib_addr[i] <= `DBU_RST_WORD;
                ib_ctrl[i] <= `DBU_RST_IB_CTRL;
            end
        end else if (wr_ok) begin
            if (reg_addr_in == `DBU_OFF_FETCH_THREAD) begin
                fetch_thread <= reg_wdata_in[7:0];
            end
            if (reg_addr_in == `DBU_OFF_FETCH_REGNUM) begin
                fetch_regnum <= reg_wdata_in[4:0];
            end
            if (reg_addr_in == `DBU_OFF_HALT_MASK) begin
                halt_mask <= reg_wdata_in[7:0];
            end
            if (dbu_in_bank(reg_addr_in, `DBU_BANK4_MASK, `DBU_OFF_IB_ADDR)) begin
                ib_addr[reg_bank] <= reg_wdata_in;
            end
            if (dbu_in_bank(reg_addr_in, `DBU_BANK4_MASK, `DBU_OFF_IB_CTRL)) begin
                ib_ctrl[reg_bank] <= reg_wdata_in & `DBU_IBC_WR_MASK;
            end
        end
    end

    // scratch words, status port wins a same-word collision
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (j = 0; j < NUM_SCRATCH; j = j + 1) begin
                scratch[j] <= `DBU_RST_WORD;
            end
        end else begin
            if (cfg_wr_in & dbu_in_bank(cfg_addr_in, `DBU_SCRATCH_MASK, `DBU_OFF_SCRATCH)) begin
                scratch[cfg_scr] <= cfg_wdata_in;
            end
            if (wr_ok & dbu_in_bank(reg_addr_in, `DBU_SCRATCH_MASK, `DBU_OFF_SCRATCH)) begin
                scratch[reg_scr] <= reg_wdata_in;
            end
        end
    end

    // status port read mux
    always @* begin
        rd_word = 32'h00000000;
        case (reg_addr_in)
            `DBU_OFF_SAVED_STATUS: rd_word = {21'h0, saved_status};
            `DBU_OFF_SAVED_PC: rd_word = saved_pc;
            `DBU_OFF_SAVED_SP: rd_word = saved_sp;
            `DBU_OFF_FETCH_THREAD: rd_word = {24'h000000, fetch_thread};
            `DBU_OFF_FETCH_REGNUM: rd_word = {27'h0, fetch_regnum};
            `DBU_OFF_CAUSE_INFO: rd_word = {14'h0, cause_index, cause_thread, 5'h00, cause};
            `DBU_OFF_CAUSE_DATA: rd_word = cause_data;
            `DBU_OFF_HALT_MASK: rd_word = {24'h000000, halt_mask};
            default: begin
                if (dbu_in_bank(reg_addr_in, `DBU_SCRATCH_MASK, `DBU_OFF_SCRATCH)) begin
                    rd_word = scratch[reg_scr];
                end else if (dbu_in_bank(reg_addr_in, `DBU_BANK4_MASK, `DBU_OFF_IB_ADDR)) begin
                    rd_word = ib_addr[reg_bank];
                end else if (dbu_in_bank(reg_addr_in, `DBU_BANK4_MASK, `DBU_OFF_IB_CTRL)) begin
                    rd_word = ib_ctrl[reg_bank];
                end else begin
                    rd_word = 32'h00000000;
                end
            end
        endcase
    end

    // config port read mux, scratch only
    always @* begin
        cfg_word = 32'h00000000;
        if (dbu_in_bank(cfg_addr_in, `DBU_SCRATCH_MASK, `DBU_OFF_SCRATCH)) begin
            cfg_word = scratch[cfg_scr];
        end
    end

    // registered read data, held between reads
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= `DBU_RST_WORD;
            cfg_rdata_out <= `DBU_RST_WORD;
        end else begin
            if (reg_rd_in) begin
                reg_rdata_out <= rd_word;
            end
            if (cfg_rd_in) begin
                cfg_rdata_out <= cfg_word;
            end
        end
    end
endmodule // dbu_breakpoint_unit

// File: tb/dbu_breakpoint_unit_assertions.sv
// checker for the debug breakpoint unit: entry sequence, captures, field masks.
// assumes it is bound onto dbu_breakpoint_unit, single clock mclk_in.
`timescale 1ns/1ns
module dbu_breakpoint_unit_assertions #(
    parameter NUM_BREAKS = 4,
    parameter NUM_SCRATCH = 8
) (
    input wire mclk_in,
    input wire rst_in,
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [31:0] reg_wdata_in,
    input wire [31:0] reg_rdata_out,
    input wire host_req_in,
    input wire [10:0] ctx_ssr_in,
    input wire [31:0] ctx_pc_in,
    input wire [31:0] ctx_sp_in,
    input wire ctx_capture_out,
    input wire debug_enter_out,
    input wire debug_mode_out,
    input wire [7:0] thread_halt_out,
    input wire [4:0] fetch_regnum_out,
    input wire [10:0] saved_status_word_out,
    input wire [31:0] saved_program_counter_out,
    input wire [31:0] saved_stack_pointer_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // write that the unit accepts: debug state, not the enter cycle
    wire dbg_wr = reg_wr_in && debug_mode_out && !debug_enter_out;
    capture_then_enter_a: assert property (ctx_capture_out |=> debug_enter_out ##1 !debug_enter_out)
        else $error("enter pulse missing after capture");
    status_capture_a: assert property (ctx_capture_out |=> saved_status_word_out == ($past(ctx_ssr_in) & 11'h7df))
        else $error("saved status differs from context");
    pc_capture_a: assert property (ctx_capture_out |=> saved_program_counter_out == $past(ctx_pc_in))
        else $error("saved pc differs from context");
    sp_capture_a: assert property (ctx_capture_out |=> saved_stack_pointer_out == $past(ctx_sp_in))
        else $error("saved sp differs from context");
    halt_in_debug_a: assert property (debug_mode_out |-> thread_halt_out == 8'h00)
        else $error("threads halted while in debug mode");
    host_entry_a: assert property (host_req_in && !debug_mode_out && !ctx_capture_out |=> ctx_capture_out)
        else $error("host request not taken");
    regnum_mask_a: assert property (dbg_wr && reg_addr_in == 8'h14 |=> {27'h0, fetch_regnum_out} == ($past(reg_wdata_in) & 32'h1f))
        else $error("register number operand wrong");
    reserved_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h13 |=> reg_rdata_out[31:8] == 24'h0)
        else $error("reserved operand bits not zero");
    // main scenarios reached
    cover property (ctx_capture_out && $past(host_req_in));
    cover property (dbg_wr && reg_addr_in == 8'h18);
    cover property (debug_enter_out ##[1:40] !debug_mode_out);
endmodule // dbu_breakpoint_unit_assertions

// File: tb/dbu_core_model.sv
// core context model: presents the context of the thread the unit names.
// assumes the unit samples the context only while capture is high.
`timescale 1ns/1ns
module dbu_core_model (
    input wire [2:0] ctx_thread_in,
    input wire ctx_capture_in,
    output reg [10:0] ctx_ssr_out,
    output reg [31:0] ctx_pc_out,
    output reg [31:0] ctx_sp_out
);
    // true context in capture only, inverted otherwise so late sampling shows
    always @* begin
        ctx_ssr_out = 11'h7ff ^ {8'h00, ctx_thread_in};
        ctx_pc_out = 32'h40000100 + 4 * ctx_thread_in;
        ctx_sp_out = 32'h80000000 - 16 * ctx_thread_in;
        if (!ctx_capture_in) begin
            ctx_ssr_out = ~ctx_ssr_out;
            ctx_pc_out = ~ctx_pc_out;
            ctx_sp_out = ~ctx_sp_out;
        end
    end
endmodule // dbu_core_model

// File: tb/dbu_breakpoint_unit_tb.sv
// self-checking bench for the debug breakpoint unit.
// assumes the core context model and the checker are compiled alongside.
`timescale 1ns/1ns
module dbu_breakpoint_unit_tb;
    logic mclk_in = 0, rst_in = 1, reg_wr_in, reg_rd_in, cfg_wr_in, cfg_rd_in;
    logic host_req_in, debug_call_instr_in, pc_valid_in, debug_return_in;
    logic ctx_capture_out, debug_enter_out, debug_mode_out;
    logic [7:0] reg_addr_in, cfg_addr_in, thread_halt_out, fetch_thread_out;
    logic [31:0] reg_wdata_in, cfg_wdata_in, pc_in, dwatch_addr_in, rwatch_resid_in;
    logic [31:0] reg_rdata_out, cfg_rdata_out, ctx_pc_in, ctx_sp_in;
    logic [31:0] saved_program_counter_out, saved_stack_pointer_out, d, m, scr [0:7];
    logic [2:0] debug_call_instr_thread_in, pc_thread_in, dwatch_thread_in, rwatch_thread_in, ctx_thread_out;
    logic [3:0] dwatch_hit_in, rwatch_hit_in;
    logic [10:0] ctx_ssr_in, saved_status_word_out;
    logic [4:0] fetch_regnum_out;
    integer n_fail = 0, tests_run = 0, i;
    // register numbers and their writable bits
    logic [7:0] ra [0:6] = '{8'h13, 8'h14, 8'h11, 8'h12, 8'h15, 8'h16, 8'h18};
    logic [31:0] rm [0:6] = '{32'hff, 32'h1f, '1, '1, 32'h3ff07, '1, 32'hff};
    // breakpoint setup and pc trials
    logic [31:0] bc [0:3] = '{32'h80000, 32'h80001, 32'h80001, 32'h400003};
    logic [31:0] ba [0:3] = '{32'h100, 32'h200, 32'h200, 32'h300};
    logic [31:0] tp [0:4] = '{32'h100, 32'h200, 32'h200, 32'h300, 32'h0};
    logic [2:0] tt [0:4] = '{3'h3, 3'h5, 3'h3, 3'h6, 3'h6};
    logic th [0:4] = '{0, 0, 1, 0, 1};
    logic [31:0] tc [0:4] = '{0, 0, 32'h10303, 0, 32'h30603};
    dbu_breakpoint_unit i_dut (.mclk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
        .reg_wdata_in, .reg_rdata_out, .cfg_addr_in, .cfg_wr_in, .cfg_rd_in, .cfg_wdata_in,
        .cfg_rdata_out, .host_req_in, .debug_call_instr_in, .debug_call_instr_thread_in, .pc_valid_in, .pc_in,
        .pc_thread_in, .dwatch_hit_in, .dwatch_thread_in, .dwatch_addr_in, .rwatch_hit_in,
        .rwatch_thread_in, .rwatch_resid_in, .ctx_ssr_in, .ctx_pc_in, .ctx_sp_in,
        .debug_return_in, .ctx_thread_out, .ctx_capture_out, .debug_enter_out,
        .debug_mode_out, .thread_halt_out, .fetch_thread_out, .fetch_regnum_out,
        .saved_status_word_out, .saved_program_counter_out, .saved_stack_pointer_out);
    dbu_core_model i_core (.ctx_thread_in(ctx_thread_out), .ctx_capture_in(ctx_capture_out),
        .ctx_ssr_out(ctx_ssr_in), .ctx_pc_out(ctx_pc_in), .ctx_sp_out(ctx_sp_in));
    // core clock, 8 ns
    always #4 mclk_in = ~mclk_in;
    task step; @(posedge mclk_in); #1; endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // status port and config port cycles, strobe one cycle then idle one
    task wr(input [7:0] a, input [31:0] v);
        reg_addr_in = a; reg_wdata_in = v; reg_wr_in = 1; step; reg_wr_in = 0; step;
    endtask
    task rd(input [7:0] a);
        reg_addr_in = a; reg_rd_in = 1; step; reg_rd_in = 0; d = reg_rdata_out; step;
    endtask
    task cwr(input [7:0] a, input [31:0] v);
        cfg_addr_in = a; cfg_wdata_in = v; cfg_wr_in = 1; step; cfg_wr_in = 0; step;
    endtask
    task crd(input [7:0] a);
        cfg_addr_in = a; cfg_rd_in = 1; step; cfg_rd_in = 0; d = cfg_rdata_out; step;
    endtask
    // trigger already driven: check capture, saved context and cause word
    task go(input logic hit, input logic [2:0] t, input logic [31:0] ci);
        step;
        {host_req_in, debug_call_instr_in, pc_valid_in, dwatch_hit_in, rwatch_hit_in} = 11'h0;
        chk(ctx_capture_out, hit);
        if (hit) begin
            chk(ctx_thread_out, t);
            step;
            chk(debug_enter_out, 1);
            chk(saved_status_word_out, 11'h7df & (11'h7ff ^ t));
            chk(saved_program_counter_out, 32'h40000100 + 4 * t);
            chk(saved_stack_pointer_out, 32'h80000000 - 16 * t);
            rd(8'h15);
            chk(d, ci);
        end else begin
            step;
            chk(debug_mode_out, 0);
        end
    endtask
    task ret;
        debug_return_in = 1; step; debug_return_in = 0; step;
        chk(debug_mode_out, 0);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #100000;
        n_fail++;
        print_verdict;
    end
    initial begin
        {reg_wr_in, reg_rd_in, cfg_wr_in, cfg_rd_in, host_req_in, debug_call_instr_in} = 6'h0;
        {pc_valid_in, debug_return_in, dwatch_hit_in, rwatch_hit_in} = 10'h0;
        {reg_addr_in, cfg_addr_in, reg_wdata_in, cfg_wdata_in, pc_in} = 112'h0;
        {dwatch_addr_in, rwatch_resid_in, debug_call_instr_thread_in, pc_thread_in} = 70'h0;
        {dwatch_thread_in, rwatch_thread_in} = 6'h0;
        m = $urandom(32'h95552e43);
        repeat (5) @(posedge mclk_in);
        #1 rst_in = 0;
        step;
        rd(8'h15);
        chk(d, 0);
        wr(8'h18, 32'hff);
        host_req_in = 1;
        go(1, 0, 32'h1);
        rd(8'h18);
        chk(d, 0);
        for (i = 0; i < 7; i++) begin
            m = $urandom;
            wr(ra[i], m);
            rd(ra[i]);
            chk(d, m & rm[i]);
            if (i == 0) chk(fetch_thread_out, m & 32'hff);
        end
        m = $urandom;
        wr(8'h10, m);
        rd(8'h10);
        chk(d, (m & 32'h6df) | 32'h100);
        wr(8'h18, 32'h0a);
        for (i = 0; i < 8; i++) begin
            scr[i] = $urandom;
            if (i % 2) cwr(8'h20 + i, scr[i]); else wr(8'h20 + i, scr[i]);
        end
        for (i = 0; i < 8; i++) begin
            rd(8'h20 + i);
            chk(d, scr[i]);
            crd(8'h20 + i);
            chk(d, scr[i]);
        end
        crd(8'h30);
        chk(d, 0);
        rd(8'h17);
        chk(d, 0);
        for (i = 0; i < 4; i++) begin
            wr(8'h30 + i, ba[i]);
            wr(8'h40 + i, bc[i] | 32'hff00fffc);
            rd(8'h40 + i);
            chk(d, bc[i]);
        end
        ret;
        chk(thread_halt_out, 8'h0a);
        for (i = 0; i < 5; i++) begin
            pc_in = (i == 4) ? ($urandom | 32'h1) : tp[i];
            pc_thread_in = tt[i];
            pc_valid_in = 1;
            go(th[i], tt[i], tc[i]);
            if (th[i]) ret;
        end
        debug_call_instr_thread_in = 3'h4;
        debug_call_instr_in = 1;
        go(1, 4, 32'h402);
        ret;
        dwatch_addr_in = $urandom;
        dwatch_thread_in = 3'h2;
        dwatch_hit_in = 4'h6;
        go(1, 2, 32'h10204);
        rd(8'h16);
        chk(d, dwatch_addr_in);
        ret;
        rwatch_resid_in = $urandom;
        rwatch_thread_in = 3'h7;
        rwatch_hit_in = 4'h8;
        go(1, 7, 32'h30705);
        rd(8'h16);
        chk(d, rwatch_resid_in);
        ret;
        print_verdict;
    end
endmodule // dbu_breakpoint_unit_tb
bind dbu_breakpoint_unit dbu_breakpoint_unit_assertions #(.NUM_BREAKS(NUM_BREAKS),
    .NUM_SCRATCH(NUM_SCRATCH)) i_chk (.mclk_in, .rst_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .host_req_in, .ctx_ssr_in, .ctx_pc_in,
    .ctx_sp_in, .ctx_capture_out, .debug_enter_out, .debug_mode_out, .thread_halt_out,
    .fetch_regnum_out, .saved_status_word_out, .saved_program_counter_out,
    .saved_stack_pointer_out);
